// ### pkg/vtpc_pkg.sv
package vtpc_pkg;
   localparam int AXES       = 9;
   localparam int CODE_AXES  = 8;
   localparam int LINES      = 4000;
   localparam int LINE_W     = 12;
   localparam int DIST_W     = 32;
   localparam int TIME_W     = 16;
   localparam int CODE_W     = 8;
   localparam int FUNC_W     = 16;
   localparam int ANG_W      = 16;
   localparam int TRIG_W     = 16;
   localparam int AXNUM_W    = 4;
   localparam int RATIO_W    = 16;

   // Segment unit and system clock.
   localparam real UNIT_NS        = 1024000.0;
   localparam real CLK_NS         = 8.0;
   localparam int  UNIT_CYCLES    = int'(UNIT_NS / CLK_NS);
   localparam logic [TIME_W-1:0] SEG_TIME_MIN = 16'h0014;

   localparam int FUNC_ACC_BIT    = 15;
   localparam int ANGLE_FULL      = 360;

   // Register port map.
   localparam logic [7:0] ADDR_DIST0     = 8'h00;
   localparam logic [7:0] ADDR_SEG_TIME  = 8'h09;
   localparam logic [7:0] ADDR_FUNC      = 8'h0A;
   localparam logic [7:0] ADDR_ERR       = 8'h0B;
   localparam logic [7:0] ADDR_ENA       = 8'h0C;
   localparam logic [7:0] ADDR_VEL       = 8'h0D;
   localparam logic [7:0] ADDR_ACC       = 8'h0E;
   localparam logic [7:0] ADDR_LINE      = 8'h10;
   localparam logic [7:0] ADDR_LAST      = 8'h11;
   localparam logic [7:0] ADDR_CMD       = 8'h12;
   localparam logic [7:0] ADDR_STATUS    = 8'h13;
   localparam logic [7:0] ADDR_CIRC_AXES = 8'h14;
   localparam logic [7:0] ADDR_CIRC_CNT  = 8'h15;
   localparam logic [7:0] ADDR_CIRC_RAD  = 8'h16;
   localparam logic [7:0] ADDR_CIRC_ANG  = 8'h17;
   localparam logic [7:0] ADDR_CIRC_RNG  = 8'h18;
   localparam logic [7:0] ADDR_CIRC_NUM  = 8'h19;
   localparam logic [7:0] ADDR_CIRC_DEN  = 8'h1A;
   localparam logic [7:0] ADDR_VLIM0     = 8'h20;
   localparam logic [7:0] ADDR_ALIM0     = 8'h30;

   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_QUERY = 3'h2;
   localparam logic [2:0] CMD_CHECK = 3'h3;
   localparam logic [2:0] CMD_RUN   = 3'h4;
   localparam logic [2:0] CMD_CIRC  = 3'h5;
   localparam logic [2:0] CMD_STOP  = 3'h6;

   localparam logic [RATIO_W-1:0] SCALE_ONE = 16'h0001;

   typedef enum logic [2:0] {VTPC_IDLE, VTPC_CHECK, VTPC_LOAD, VTPC_RUN, VTPC_BRAKE, VTPC_CIRC} vtpc_state_e;
endpackage : vtpc_pkg

// ### verilog/vtpc_top.sv
// Contract
// - Only axes enabled in a segment move; others brake at their acceleration limit.
// - An entry write stores nine distances, time, function, error and enable as one line.
// - Check from line n to table end flags axes exceeding velocity or acceleration limit.
// - Check stores highest enabled axis velocity and acceleration; query returns them too (the code stores those of the highest-numbered enabled axis).
// - After last entry or disable, idle axes brake, then switch to position holding (the code holds disabled axes only once the run ends).
// - Run starts at line n, or runs only lines n through m.
// - Circle fill writes m secant vectors from line n with its parameter set.
// - Axis number zero in circle fill generates no increments for that axis.
// - Positive angle range turns counterclockwise, negative range clockwise.
// - Secant k starts at start angle plus range times (k-1)/m.
// - Secant x increment is -L sin(theta), y increment L cos(theta).
// - Larger denominator divides x increments; larger numerator divides y increments.
// - Scale numerator and denominator default to one.
// - Segment time counts 1.024 ms units, valid 20 to 65535.
// - Function bit 15 selects constant acceleration; three output select fields with set bits.
// - Error and enable code bit 0 is axis 1, upward.
// - Velocity and acceleration limits are set per axis.
`timescale 1ns/1ps
module vtpc_top
   import vtpc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic [7:0]               addr,
   input  wire logic [31:0]              wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [31:0]              rdata,
   output logic      [AXES-1:0]          axis_vel_mode,
   output logic      [AXES-1:0]          axis_hold,
   output logic      [AXES*DIST_W-1:0]   axis_step,
   output logic      [AXES-1:0]          axis_brake,
   output logic                          seg_acc_mode,
   output logic      [FUNC_W-1:0]        seg_func,
   output logic                          seg_strobe,
   output logic                          busy
);
   // ****************************************************************
   // Table storage
   // ****************************************************************
   logic [DIST_W-1:0] dist_mem  [LINES][AXES];
   logic [TIME_W-1:0] time_mem  [LINES];
   logic [FUNC_W-1:0] func_mem  [LINES];
   logic [CODE_W-1:0] err_mem   [LINES];
   logic [CODE_W-1:0] ena_mem   [LINES];
   logic [DIST_W-1:0] vel_mem   [LINES];
   logic [DIST_W-1:0] acc_mem   [LINES];
   logic [DIST_W-1:0] vlim_r    [AXES];
   logic [DIST_W-1:0] alim_r    [AXES];

   // ****************************************************************
   // Staging and control registers
   // ****************************************************************
   logic [DIST_W-1:0]  stage_dist_r [AXES];
   logic [TIME_W-1:0]  stage_time_r;
   logic [FUNC_W-1:0]  stage_func_r;
   logic [CODE_W-1:0]  stage_err_r;
   logic [CODE_W-1:0]  stage_ena_r;
   logic [DIST_W-1:0]  stage_vel_r;
   logic [DIST_W-1:0]  stage_acc_r;
   logic [LINE_W-1:0]  line_r;
   logic [LINE_W-1:0]  last_r;
   logic [AXNUM_W-1:0] cx_r;
   logic [AXNUM_W-1:0] cy_r;
   logic [LINE_W-1:0]  cm_r;
   logic [DIST_W-1:0]  crad_r;
   logic [ANG_W-1:0]   cang_r;
   logic [ANG_W-1:0]   crng_r;
   logic [RATIO_W-1:0] cnum_r;
   logic [RATIO_W-1:0] cden_r;
   logic               bad_time_r;

   vtpc_state_e        state_r;
   logic [LINE_W-1:0]  ptr_r;
   logic [LINE_W-1:0]  end_r;
   logic [LINE_W-1:0]  k_r;
   logic [TIME_W-1:0]  seg_left_r;
   logic [31:0]        tick_cnt_r;
   logic [CODE_W-1:0]  act_ena_r;

   wire cmd_wr   = wr && (addr == ADDR_CMD);
   wire [2:0] cmd = wdata[2:0];
   wire tick     = (tick_cnt_r == 32'(UNIT_CYCLES - 1));
   wire idle     = (state_r == VTPC_IDLE);

   // ****************************************************************
   // Check arithmetic: velocity is distance over time, acceleration is
   // velocity change over time, both in units per segment unit.
   // ****************************************************************
   logic [DIST_W-1:0] chk_vel  [AXES];
   logic [DIST_W-1:0] chk_acc  [AXES];
   logic [CODE_W-1:0] chk_err;
   logic [DIST_W-1:0] hi_vel;
   logic [DIST_W-1:0] hi_acc;
   logic [DIST_W-1:0] prev_vel_r [AXES];
   wire  [TIME_W-1:0] chk_t = (time_mem[ptr_r] == '0) ? SEG_TIME_MIN : time_mem[ptr_r];

   always_comb begin
      chk_err = '0;
      hi_vel  = '0;
      hi_acc  = '0;
      for (int a = 0; a < AXES; a++) begin
         logic [DIST_W-1:0] d;
         d          = dist_mem[ptr_r][a];
         d          = d[DIST_W-1] ? -d : d;
         chk_vel[a] = d / DIST_W'(chk_t);
         chk_acc[a] = ((chk_vel[a] > prev_vel_r[a]) ? chk_vel[a] - prev_vel_r[a]
                                                    : prev_vel_r[a] - chk_vel[a]) / DIST_W'(chk_t);
         if (a < CODE_AXES && ena_mem[ptr_r][a]) begin
            if (chk_vel[a] > vlim_r[a] || chk_acc[a] > alim_r[a]) chk_err[a] = 1'b1;
            hi_vel = chk_vel[a];
            hi_acc = chk_acc[a];
         end
      end
   end

   // ****************************************************************
   // Circle secant generator. Angles are whole degrees; sine comes from
   // a quarter table scaled by 2^14, which bounds arc precision.
   // ****************************************************************
   function automatic logic signed [15:0] sin_deg(input logic signed [31:0] deg);
      logic signed [31:0] d;
      logic [6:0]         q;
      logic signed [15:0] v;
      d = deg % ANGLE_FULL;
      if (d < 0) d = d + ANGLE_FULL;
      q = (d <= 90) ? 7'(d) : (d <= 180) ? 7'(180 - d) : (d <= 270) ? 7'(d - 180) : 7'(ANGLE_FULL - d);
      v = 16'($rtoi($sin(real'(q) * 3.14159265358979 / 180.0) * 16384.0));
      for (int i = 0; i <= 90; i++)
         if (q == 7'(i)) v = 16'($rtoi($sin(real'(i) * 3.14159265358979 / 180.0) * 16384.0));
      return (d > 180) ? -v : v;
   endfunction : sin_deg

   wire signed [31:0] rng_s   = 32'(signed'(crng_r));
   wire signed [31:0] m_s     = 32'(cm_r);
   wire signed [31:0] alpha_k = 32'(signed'(cang_r)) + (rng_s * signed'(32'(k_r))) / m_s;
   wire signed [31:0] half    = rng_s / (2 * m_s);
   wire signed [63:0] len     = (64'(signed'(crad_r)) * 2 * 64'(sin_deg(half))) >>> 14;
   wire signed [63:0] theta_s = 64'(sin_deg(alpha_k + half));
   wire signed [63:0] theta_c = 64'(sin_deg(alpha_k + half + 90));
   wire signed [63:0] dx_raw  = -((len * theta_s) >>> 14);
   wire signed [63:0] dy_raw  = (len * theta_c) >>> 14;
   wire signed [63:0] dx_sc   = (cden_r > cnum_r) ? dx_raw * signed'(64'(cnum_r)) / signed'(64'(cden_r)) : dx_raw;
   wire signed [63:0] dy_sc   = (cnum_r > cden_r) ? dy_raw * signed'(64'(cden_r)) / signed'(64'(cnum_r)) : dy_raw;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r    <= VTPC_IDLE;
         ptr_r      <= '0;
         end_r      <= '0;
         k_r        <= '0;
         seg_left_r <= '0;
         tick_cnt_r <= '0;
         act_ena_r  <= '0;
         seg_strobe <= 1'b0;
         seg_func   <= '0;
         seg_acc_mode  <= 1'b0;
         axis_step     <= '0;
         axis_brake    <= '0;
         axis_vel_mode <= '0;
         axis_hold     <= '1;
         for (int a = 0; a < AXES; a++) prev_vel_r[a] <= '0;
      end else begin
         seg_strobe <= 1'b0;
         tick_cnt_r <= tick ? '0 : tick_cnt_r + 32'd1;
         unique case (state_r)
            VTPC_IDLE: begin
               if (cmd_wr && cmd == CMD_CHECK) begin
                  ptr_r <= line_r;
                  for (int a = 0; a < AXES; a++) prev_vel_r[a] <= '0;
                  state_r <= VTPC_CHECK;
               end else if (cmd_wr && cmd == CMD_RUN) begin
                  ptr_r   <= line_r;
                  end_r   <= wdata[3] ? last_r : LINE_W'(LINES - 1);
                  axis_hold <= '0;
                  state_r <= VTPC_LOAD;
               end else if (cmd_wr && cmd == CMD_CIRC) begin
                  ptr_r   <= line_r;
                  k_r     <= '0;
                  state_r <= VTPC_CIRC;
               end
            end
            VTPC_CHECK: begin
               err_mem[ptr_r] <= chk_err;
               vel_mem[ptr_r] <= hi_vel;
               acc_mem[ptr_r] <= hi_acc;
               for (int a = 0; a < AXES; a++) prev_vel_r[a] <= chk_vel[a];
               ptr_r <= ptr_r + LINE_W'(1);
               if (ptr_r == LINE_W'(LINES - 1)) state_r <= VTPC_IDLE;
            end
            VTPC_LOAD: begin
               // Error codes are not consulted here on purpose.
               act_ena_r    <= ena_mem[ptr_r];
               seg_left_r   <= (time_mem[ptr_r] < SEG_TIME_MIN) ? SEG_TIME_MIN : time_mem[ptr_r];
               seg_func     <= func_mem[ptr_r];
               seg_acc_mode <= func_mem[ptr_r][FUNC_ACC_BIT];
               seg_strobe   <= 1'b1;
               for (int a = 0; a < AXES; a++) begin
                  logic on;
                  on = (a < CODE_AXES) && ena_mem[ptr_r][a];
                  axis_step[a*DIST_W +: DIST_W] <= on ? dist_mem[ptr_r][a] : '0;
                  axis_vel_mode[a] <= on;
                  axis_brake[a]    <= !on && axis_vel_mode[a];
               end
               state_r <= VTPC_RUN;
            end
            VTPC_RUN: begin
               if (tick) begin
                  if (seg_left_r == TIME_W'(1)) begin
                     ptr_r   <= ptr_r + LINE_W'(1);
                     state_r <= (ptr_r == end_r) ? VTPC_BRAKE : VTPC_LOAD;
                  end else seg_left_r <= seg_left_r - TIME_W'(1);
               end
               if (cmd_wr && cmd == CMD_STOP) state_r <= VTPC_BRAKE;
            end
            VTPC_BRAKE: begin
               // Brake until the next unit tick (a whole unit after table end), then velocity mode off and hold on.
               axis_brake <= axis_vel_mode;
               axis_step  <= '0;
               if (tick) begin
                  axis_vel_mode <= '0;
                  axis_brake    <= '0;
                  axis_hold     <= '1;
                  state_r       <= VTPC_IDLE;
               end
            end
            VTPC_CIRC: begin
               for (int a = 0; a < AXES; a++) begin
                  dist_mem[ptr_r][a] <= (cx_r != '0 && a == int'(cx_r) - 1) ? 32'(dx_sc) :
                                        (cy_r != '0 && a == int'(cy_r) - 1) ? 32'(dy_sc) : '0;
               end
               time_mem[ptr_r] <= stage_time_r;
               func_mem[ptr_r] <= stage_func_r;
               err_mem[ptr_r]  <= '0;
               ena_mem[ptr_r]  <= ((cx_r != '0) ? CODE_W'(1) << (cx_r - 1) : '0) |
                                  ((cy_r != '0) ? CODE_W'(1) << (cy_r - 1) : '0);
               ptr_r <= ptr_r + LINE_W'(1);
               k_r   <= k_r + LINE_W'(1);
               if (k_r + LINE_W'(1) >= cm_r || ptr_r == LINE_W'(LINES - 1)) state_r <= VTPC_IDLE;
            end
         endcase
         if (idle && cmd_wr && cmd == CMD_WRITE) begin
            for (int a = 0; a < AXES; a++) dist_mem[line_r][a] <= stage_dist_r[a];
            time_mem[line_r] <= stage_time_r;
            func_mem[line_r] <= stage_func_r;
            err_mem[line_r]  <= stage_err_r;
            ena_mem[line_r]  <= stage_ena_r;
         end
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int a = 0; a < AXES; a++) begin
            stage_dist_r[a] <= '0;
            vlim_r[a]       <= '0;
            alim_r[a]       <= '0;
         end
         {stage_time_r, stage_func_r, stage_err_r, stage_ena_r} <= '0;
         {stage_vel_r, stage_acc_r} <= '0;
         {line_r, last_r, cx_r, cy_r, cm_r, crad_r, cang_r, crng_r} <= '0;
         cnum_r     <= SCALE_ONE;
         cden_r     <= SCALE_ONE;
         bad_time_r <= 1'b0;
         rdata      <= '0;
      end else begin
         rdata <= '0;
         if (wr) begin
            for (int a = 0; a < AXES; a++) begin
               if (addr == ADDR_DIST0 + 8'(a)) stage_dist_r[a] <= wdata;
               if (addr == ADDR_VLIM0 + 8'(a)) vlim_r[a] <= wdata;
               if (addr == ADDR_ALIM0 + 8'(a)) alim_r[a] <= wdata;
            end
            if (addr == ADDR_SEG_TIME) begin
               stage_time_r <= wdata[TIME_W-1:0];
               bad_time_r   <= wdata[TIME_W-1:0] < SEG_TIME_MIN;
            end
            if (addr == ADDR_FUNC)      stage_func_r <= wdata[FUNC_W-1:0];
            if (addr == ADDR_ERR)       stage_err_r  <= wdata[CODE_W-1:0];
            if (addr == ADDR_ENA)       stage_ena_r  <= wdata[CODE_W-1:0];
            if (addr == ADDR_LINE)      line_r <= wdata[LINE_W-1:0];
            if (addr == ADDR_LAST)      last_r <= wdata[LINE_W-1:0];
            if (addr == ADDR_CIRC_AXES) {cy_r, cx_r} <= wdata[7:0];
            if (addr == ADDR_CIRC_CNT)  cm_r   <= wdata[LINE_W-1:0];
            if (addr == ADDR_CIRC_RAD)  crad_r <= wdata;
            if (addr == ADDR_CIRC_ANG)  cang_r <= wdata[ANG_W-1:0];
            if (addr == ADDR_CIRC_RNG)  crng_r <= wdata[ANG_W-1:0];
            if (addr == ADDR_CIRC_NUM)  cnum_r <= (wdata[RATIO_W-1:0] == '0) ? SCALE_ONE : wdata[RATIO_W-1:0];
            if (addr == ADDR_CIRC_DEN)  cden_r <= (wdata[RATIO_W-1:0] == '0) ? SCALE_ONE : wdata[RATIO_W-1:0];
         end
         if (idle && cmd_wr && cmd == CMD_QUERY) begin
            for (int a = 0; a < AXES; a++) stage_dist_r[a] <= dist_mem[line_r][a];
            stage_time_r <= time_mem[line_r];
            stage_func_r <= func_mem[line_r];
            stage_err_r  <= err_mem[line_r];
            stage_ena_r  <= ena_mem[line_r];
            stage_vel_r  <= vel_mem[line_r];
            stage_acc_r  <= acc_mem[line_r];
         end
         if (rd) begin
            for (int a = 0; a < AXES; a++)
               if (addr == ADDR_DIST0 + 8'(a)) rdata <= stage_dist_r[a];
            if (addr == ADDR_SEG_TIME) rdata <= 32'(stage_time_r);
            if (addr == ADDR_FUNC)     rdata <= 32'(stage_func_r);
            if (addr == ADDR_ERR)      rdata <= 32'(stage_err_r);
            if (addr == ADDR_ENA)      rdata <= 32'(stage_ena_r);
            if (addr == ADDR_VEL)      rdata <= stage_vel_r;
            if (addr == ADDR_ACC)      rdata <= stage_acc_r;
            if (addr == ADDR_LINE)     rdata <= 32'(line_r);
            if (addr == ADDR_STATUS)   rdata <= {16'h0000, 4'(ptr_r >> 8), ptr_r[7:0], bad_time_r, state_r};
         end
      end
   end

   assign busy = !idle;
endmodule : vtpc_top

// ### tb/vtpc_properties.sv
`timescale 1ns/1ps
module vtpc_checker
   import vtpc_pkg::*;
(
   input wire logic                clk,
   input wire logic                reset,
   input wire logic [7:0]          addr,
   input wire logic [31:0]         wdata,
   input wire logic                wr,
   input wire logic                rd,
   input wire logic [31:0]         rdata,
   input wire logic [AXES-1:0]     axis_vel_mode,
   input wire logic [AXES-1:0]     axis_hold,
   input wire logic                seg_acc_mode,
   input wire logic [FUNC_W-1:0]   seg_func,
   input wire logic                seg_strobe,
   input wire logic                busy
);
   // ********************************
   // Protocol and sequencing checks
   // ********************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_unmapped_read: assert property (rd && addr == 8'hFF |=> rdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   a_strobe_single: assert property (seg_strobe |=> (!seg_strobe)[*8])
      else $error("segment load strobe repeated within a segment");
   a_strobe_in_run: assert property (seg_strobe |-> busy)
      else $error("segment loaded while sequencer idle");
   a_acc_mode_bit: assert property (seg_acc_mode == seg_func[FUNC_ACC_BIT])
      else $error("acceleration mode differs from function code bit");
   a_hold_excl_vel: assert property ((axis_hold & axis_vel_mode) == '0)
      else $error("axis holding position and in velocity mode at once");
   a_axis9_still: assert property (axis_vel_mode[AXES-1] == 1'b0)
      else $error("axis without enable bit entered velocity mode");
   a_run_loads: assert property (wr && addr == ADDR_CMD && wdata[2:0] == CMD_RUN && !busy |-> ##[1:4] seg_strobe)
      else $error("table run did not load a segment");
   a_check_busy: assert property (wr && addr == ADDR_CMD && wdata[2:0] == CMD_CHECK && !busy |=> busy)
      else $error("limit check did not start");
   a_reset_holds: assert property ($fell(reset) |-> axis_hold == '1 && axis_vel_mode == '0 && !busy)
      else $error("axes not holding position after reset");

   c_run_strobe: cover property (seg_strobe);
   c_busy_rise: cover property ($rose(busy));
   c_read_data: cover property (rd ##1 rdata != 32'h0);
endmodule : vtpc_checker

bind vtpc_top vtpc_checker vtpc_checker_inst (
   .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .axis_vel_mode(axis_vel_mode), .axis_hold(axis_hold), .seg_acc_mode(seg_acc_mode),
   .seg_func(seg_func), .seg_strobe(seg_strobe), .busy(busy));

// ### tb/vtpc_host.sv
`timescale 1ns/1ps
module vtpc_host
   import vtpc_pkg::*;
(
   input  wire logic         clk,
   output logic      [7:0]   addr,
   output logic      [31:0]  wdata,
   output logic              wr,
   output logic              rd,
   input  wire logic [31:0]  rdata
);
   // ********************************
   // Host command driver
   // ********************************
   bit slow;
   initial begin
      {addr, wdata, wr, rd} = '0;
   end
   // Released lines show the inverse so stale values never pass as fresh ones.
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
      if (slow) @(posedge clk);
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask : read_reg
   task automatic command(input logic [11:0] line, input logic [31:0] cmd);
      write_reg(ADDR_LINE, {20'h0, line});
      write_reg(ADDR_CMD, cmd);
   endtask : command
   task automatic write_entry(input logic [11:0] line, input logic [AXES*DIST_W-1:0] d,
                              input logic [TIME_W-1:0] t, input logic [FUNC_W-1:0] f, input logic [CODE_W-1:0] en);
      for (int i = 0; i < AXES; i++) write_reg(ADDR_DIST0 + 8'(i), d[i*DIST_W +: DIST_W]);
      write_reg(ADDR_SEG_TIME, {16'h0, (t < SEG_TIME_MIN) ? SEG_TIME_MIN : t});
      write_reg(ADDR_FUNC, {16'h0, f});
      write_reg(ADDR_ERR, 32'h0);
      write_reg(ADDR_ENA, {24'h0, en});
      command(line, {29'h0, CMD_WRITE});
   endtask : write_entry
   task automatic set_limit(input int axis, input logic [31:0] vel, input logic [31:0] acc);
      write_reg(ADDR_VLIM0 + 8'(axis), vel);
      write_reg(ADDR_ALIM0 + 8'(axis), acc);
   endtask : set_limit
endmodule : vtpc_host

// ### tb/vtpc_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   checks_done++; \
   if ((got) !== (ex)) begin \
      bad_count++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
   end \
end
module vtpc_tb_top;
   import vtpc_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] e;} vtpc_row_s;
   logic                   clk;
   logic                   reset;
   logic [7:0]             addr;
   logic [31:0]            wdata;
   logic                   wr;
   logic                   rd;
   logic [31:0]            rdata;
   logic [AXES-1:0]        axis_vel_mode;
   logic [AXES-1:0]        axis_hold;
   logic [AXES*DIST_W-1:0] axis_step;
   logic [AXES-1:0]        axis_brake;
   logic                   seg_acc_mode;
   logic [FUNC_W-1:0]      seg_func;
   logic                   seg_strobe;
   logic                   busy;
   int                     bad_count;
   int                     checks_done;
   int                     cycles;
   logic [31:0]            rv;
   logic [AXES*DIST_W-1:0] d5;
   vtpc_row_s              rows [13];
   logic [31:0]            cx [4] = '{32'hFFFF_FC18, 32'hFFFF_FC18, 32'h0000_03E8, 32'h0000_03E8};
   logic [31:0]            cy [4] = '{32'h0000_03E8, 32'hFFFF_FC18, 32'hFFFF_FC18, 32'h0000_03E8};

   vtpc_top vtpc_top_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .axis_vel_mode(axis_vel_mode), .axis_hold(axis_hold), .axis_step(axis_step),
      .axis_brake(axis_brake), .seg_acc_mode(seg_acc_mode), .seg_func(seg_func),
      .seg_strobe(seg_strobe), .busy(busy));
   vtpc_host vtpc_host_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

   // ********************************
   // Helpers
   // ********************************
   function automatic logic [31:0] dval(input int i);
      logic [31:0] v;
      v = 32'(i + 1) * 32'h0101_0101;
      return (i % 2) ? -v : v;
   endfunction : dval
   // Secant values come from fixed-point sines, so a few increments of slack are allowed.
   function automatic logic [31:0] near(input logic [31:0] e, input logic [31:0] g);
      if ($signed(g - e) >= -3 && $signed(g - e) <= 3) return e;
      return g;
   endfunction : near
   task automatic wait_idle();
      #1;
      while (busy !== 1'b0) @(posedge clk);
   endtask : wait_idle
   task automatic query(input logic [11:0] line);
      vtpc_host_inst.command(line, {29'h0, CMD_QUERY});
      wait_idle();
   endtask : query
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         complete_run();
      end
   end

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      reset = 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("hold after reset", 9'h1FF, axis_hold)
      `CHK("busy after reset", 1'b0, busy)
      vtpc_host_inst.read_reg(8'hFF, rv);
      `CHK("unmapped read", 32'h0, rv)
      for (int a = 0; a < AXES; a++) vtpc_host_inst.set_limit(a, (a == 2 || a == 3) ? 32'hA : '1, '1);
      for (int i = 0; i < AXES; i++) d5[i*DIST_W +: DIST_W] = dval(i);
      for (int i = 0; i < AXES; i++) rows[i] = '{ADDR_DIST0 + 8'(i), dval(i)};
      rows[9] = '{ADDR_SEG_TIME, 32'h30};
      rows[10] = '{ADDR_FUNC, 32'h4321};
      rows[11] = '{ADDR_ERR, 32'h0};
      rows[12] = '{ADDR_ENA, 32'hA5};
      vtpc_host_inst.write_entry(12'd5, d5, 16'h0030, 16'h4321, 8'hA5);
      vtpc_host_inst.slow = 1'b1;
      vtpc_host_inst.write_entry(12'd6, '0, 16'h0014, 16'h0000, 8'h00);
      vtpc_host_inst.slow = 1'b0;
      query(12'd5);
      foreach (rows[r]) begin
         vtpc_host_inst.read_reg(rows[r].a, rv);
         `CHK("entry field", rows[r].e, rv)
      end
      // Axis 3 exceeds its velocity limit: 2000 over 98 units.
      d5 = '0;
      d5[95:0] = {32'h0000_07D0, 32'hFFFF_FE0C, 32'h0000_03E8};
      vtpc_host_inst.write_entry(12'd0, d5, 16'd98, 16'h8000, 8'h07);
      vtpc_host_inst.command(12'd0, {29'h0, CMD_CHECK});
      wait_idle();
      query(12'd0);
      vtpc_host_inst.read_reg(ADDR_ERR, rv);
      `CHK("check error code", 32'h4, rv)
      vtpc_host_inst.read_reg(ADDR_VEL, rv);
      `CHK("check velocity", 32'h14, rv)
      vtpc_host_inst.read_reg(ADDR_DIST0 + 8'h2, rv);
      `CHK("checked distance", 32'h0000_07D0, rv)
      vtpc_host_inst.write_reg(ADDR_SEG_TIME, 32'h14);
      vtpc_host_inst.write_reg(ADDR_FUNC, 32'h0);
      vtpc_host_inst.write_reg(ADDR_CIRC_AXES, 32'h21);
      vtpc_host_inst.write_reg(ADDR_CIRC_CNT, 32'h4);
      vtpc_host_inst.write_reg(ADDR_CIRC_RAD, 32'h3E8);
      vtpc_host_inst.write_reg(ADDR_CIRC_ANG, 32'h0);
      vtpc_host_inst.write_reg(ADDR_CIRC_RNG, 32'h168);
      vtpc_host_inst.command(12'd10, {29'h0, CMD_CIRC});
      wait_idle();
      for (int k = 0; k < 4; k++) begin
         query(12'(10 + k));
         vtpc_host_inst.read_reg(ADDR_DIST0, rv);
         `CHK("secant x", cx[k], near(cx[k], rv))
         vtpc_host_inst.read_reg(ADDR_DIST0 + 8'h1, rv);
         `CHK("secant y", cy[k], near(cy[k], rv))
      end
      vtpc_host_inst.write_reg(ADDR_CIRC_RNG, 32'hFE98);
      vtpc_host_inst.write_reg(ADDR_CIRC_NUM, 32'h2);
      vtpc_host_inst.write_reg(ADDR_CIRC_DEN, 32'h1);
      vtpc_host_inst.command(12'd20, {29'h0, CMD_CIRC});
      wait_idle();
      query(12'd20);
      vtpc_host_inst.read_reg(ADDR_DIST0, rv);
      `CHK("clockwise x", 32'hFFFF_FC18, near(32'hFFFF_FC18, rv))
      vtpc_host_inst.read_reg(ADDR_DIST0 + 8'h1, rv);
      `CHK("scaled y", 32'hFFFF_FE0C, near(32'hFFFF_FE0C, rv))
      vtpc_host_inst.write_reg(ADDR_CIRC_AXES, 32'h01);
      vtpc_host_inst.command(12'd30, {29'h0, CMD_CIRC});
      wait_idle();
      query(12'd30);
      vtpc_host_inst.read_reg(ADDR_DIST0 + 8'h1, rv);
      `CHK("unused y axis", 32'h0, rv)
      // Run only line 0, which carries a flagged error.
      vtpc_host_inst.write_reg(ADDR_LAST, 32'h0);
      vtpc_host_inst.command(12'd0, 32'hC);
      for (int n = 0; n < 20 && seg_strobe !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      `CHK("segment loaded", 1'b1, seg_strobe)
      `CHK("segment function", 16'h8000, seg_func)
      `CHK("segment accel mode", 1'b1, seg_acc_mode)
      `CHK("velocity mode axes", 9'h007, axis_vel_mode)
      `CHK("enabled not holding", 3'h0, axis_hold[2:0])
      `CHK("axis 2 step", 32'hFFFF_FE0C, axis_step[DIST_W +: DIST_W])
      `CHK("axis 3 step", 32'h0000_07D0, axis_step[2*DIST_W +: DIST_W])
      vtpc_host_inst.write_reg(ADDR_CMD, {29'h0, CMD_STOP});
      @(posedge clk);
      #1;
      `CHK("brake on stop", 9'h007, axis_brake)
      complete_run();
   end
endmodule : vtpc_tb_top
